// [rtl/climate_link_pkg.sv]
// Purpose: Constants for the single-wire climate sensor link, device end
// Assumes: 50 MHz system clock
// Notes:   Times kept in their own units, cycle counts derived from them
package climate_link_pkg;
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned START_MIN_US    = 18_000;
   localparam int unsigned RESP_LOW_US     = 80;
   localparam int unsigned RESP_HIGH_US    = 80;
   localparam int unsigned BIT_LOW_US      = 50;
   localparam int unsigned ZERO_HIGH_US    = 26;
   localparam int unsigned ONE_HIGH_US     = 70;
   localparam int unsigned END_LOW_US      = 50;
   localparam int unsigned START_MIN_CYC   = (START_MIN_US * (CLK_HZ / 1_000_000));
   localparam int unsigned RESP_LOW_CYC    = RESP_LOW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned RESP_HIGH_CYC   = RESP_HIGH_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BIT_LOW_CYC     = BIT_LOW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned ZERO_HIGH_CYC   = ZERO_HIGH_US * (CLK_HZ / 1_000_000);
   localparam int unsigned ONE_HIGH_CYC    = ONE_HIGH_US * (CLK_HZ / 1_000_000);
   localparam int unsigned END_LOW_CYC     = END_LOW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FRAME_BITS      = 40;
   localparam int unsigned BYTE_BITS       = 8;
   localparam int unsigned FIFO_DEPTH      = 8;
   localparam int unsigned CNT_W           = 20;
   localparam logic [7:0]  FRACTION_VALUE  = 8'h00;

   typedef enum logic [2:0] {
      ST_SLEEP     = 3'b000,
      ST_WAIT_HIGH = 3'b001,
      ST_RESP_LOW  = 3'b011,
      ST_RESP_HIGH = 3'b010,
      ST_BIT_LOW   = 3'b110,
      ST_BIT_HIGH  = 3'b111,
      ST_END_LOW   = 3'b101
   } link_state_t;
endpackage

// [rtl/sample_fifo.sv]
`timescale 1ns/1ps
// Purpose: Small synchronous FIFO for measurement words
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Depth must be a power of two
module sample_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic             wr_valid_i,
   output logic                  wr_ready_o,
   output logic      [WIDTH-1:0] rd_data_o,
   output logic                  rd_valid_o,
   input  wire logic             rd_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wptr_q;
   logic [AW:0]      wptr_d;
   logic [AW:0]      rptr_q;
   logic [AW:0]      rptr_d;
   logic             push;
   logic             pop;

   assign wr_ready_o = (wptr_q - rptr_q) != (AW+1)'(DEPTH);
   assign rd_valid_o = wptr_q != rptr_q;
   assign push       = wr_valid_i && wr_ready_o;
   assign pop        = rd_valid_o && rd_ready_i;
   assign rd_data_o  = mem_q[rptr_q[AW-1:0]];

   always_comb begin
      wptr_d = wptr_q + (AW+1)'(push);
      rptr_d = rptr_q + (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wptr_q <= '0;
         rptr_q <= '0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_q[wptr_q[AW-1:0]] <= wr_data_i;
      end
   end
endmodule

// [rtl/climate_link_device.sv]
`timescale 1ns/1ps
// Purpose: Device end of the single-wire climate sensor link
// Assumes: Line input synchronous to clk_sys_i; external pull-up on the line
// Notes:   Measurements enter through an 8-word FIFO; one word serves one transaction
// Overview of operation
// [RL1] Send each reading as one 40-bit frame, most significant bit first.
// [RL2] Byte order: humidity int, humidity frac, temperature int, temperature frac, checksum.
// [RL3] Checksum is low eight bits of the sum of four data bytes.
// [RL4] Both fractional bytes are always sent as zero.
// [RL5] Wake only on a host start pulse; sleep again after the frame.
// [RL6] Never drive the line while idle; pull-up holds it high.
// [RL7] Host holds the line low over 18 ms to request a reading.
// [RL8] Host then releases the line and lets the pull-up raise it.
// [RL9] Host waits 20 to 40 us, then samples for the response.
// [RL10] After the start pulse ends, drive the line low for 80 us.
// [RL11] Then leave the line high for 80 us before the first bit.
// [RL12] Each bit: 50 us low, then a high whose length gives the value.
// [RL13] Host reports no response if the line is high when sampled.
// [RL14] After the last bit drive low 50 us, then release the line.
// [RL15] Whole transaction lasts about 4 ms.
// [RL16] Host decodes bits by thresholding the high-period length.
// [RL17] Host times out when an expected edge does not arrive.
module climate_link_device
   import climate_link_pkg::*;
#(
   parameter int unsigned START_CYC = START_MIN_CYC,
   parameter int unsigned US_CYC    = CLK_HZ / 1_000_000
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_b_i,
   input  wire logic        line_i,
   output logic             line_o,
   output logic             line_oe_o,
   input  wire logic [7:0]  humidity_i,
   input  wire logic [7:0]  temperature_i,
   input  wire logic        sample_valid_i,
   output logic             sample_ready_o,
   output logic             awake_o,
   output logic             frame_done_o
);
   import climate_link_pkg::*;

   // Pulse lengths in cycles, scaled by the cycles per microsecond
   localparam int unsigned RESP_LOW_N  = RESP_LOW_US * US_CYC;
   localparam int unsigned RESP_HIGH_N = RESP_HIGH_US * US_CYC;
   localparam int unsigned BIT_LOW_N   = BIT_LOW_US * US_CYC;
   localparam int unsigned ZERO_HIGH_N = ZERO_HIGH_US * US_CYC;
   localparam int unsigned ONE_HIGH_N  = ONE_HIGH_US * US_CYC;

   // =========================================================
   // Measurement buffer
   logic [15:0] fifo_data;
   logic        fifo_valid;
   logic        fifo_pop;

   sample_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i  (clk_sys_i),
      .rst_b_i    (rst_b_i),
      .wr_data_i  ({humidity_i, temperature_i}),
      .wr_valid_i (sample_valid_i),
      .wr_ready_o (sample_ready_o),
      .rd_data_o  (fifo_data),
      .rd_valid_o (fifo_valid),
      .rd_ready_i (fifo_pop)
   );

   // =========================================================
   // Link sequencer
   link_state_t state_q;
   link_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [39:0]      shift_q;
   logic [39:0]      shift_d;
   logic [5:0]       bits_q;
   logic [5:0]       bits_d;
   logic             drive_low_q;
   logic             drive_low_d;
   logic             done_q;
   logic             done_d;
   logic [7:0]       hum_b;
   logic [7:0]       tmp_b;
   logic [7:0]       sum_b;

   always_comb begin
      hum_b = fifo_valid ? fifo_data[15:8] : 8'h00;
      tmp_b = fifo_valid ? fifo_data[7:0] : 8'h00;
      sum_b = 8'(hum_b + FRACTION_VALUE + tmp_b + FRACTION_VALUE); // see [RL3]
   end

   always_comb begin
      state_d     = state_q;
      cnt_d       = cnt_q;
      shift_d     = shift_q;
      bits_d      = bits_q;
      drive_low_d = 1'b0;
      done_d      = 1'b0;
      fifo_pop    = 1'b0;
      unique case (state_q)
         ST_SLEEP: begin
            // Count the host's low start pulse; any high resets it, see [RL5] [RL7]
            if (!line_i) begin
               if (cnt_q < CNT_W'(START_CYC)) begin
                  cnt_d = cnt_q + CNT_W'(1);
               end else begin
                  state_d = ST_WAIT_HIGH;
               end
            end else begin
               cnt_d = '0;
            end
         end
         ST_WAIT_HIGH: begin
            // Respond only after the host releases the line, see [RL8] [RL10]
            if (line_i) begin
               state_d     = ST_RESP_LOW;
               cnt_d       = '0;
               drive_low_d = 1'b1;
               shift_d     = {hum_b, FRACTION_VALUE, tmp_b, FRACTION_VALUE, sum_b}; // see [RL2] [RL4]
               fifo_pop    = fifo_valid;
            end
         end
         ST_RESP_LOW: begin
            drive_low_d = 1'b1; // see [RL10]
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == CNT_W'(RESP_LOW_N - 1)) begin
               state_d     = ST_RESP_HIGH;
               cnt_d       = '0;
               drive_low_d = 1'b0;
            end
         end
         ST_RESP_HIGH: begin
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == CNT_W'(RESP_HIGH_N - 1)) begin // see [RL11]
               state_d     = ST_BIT_LOW;
               cnt_d       = '0;
               bits_d      = '0;
               drive_low_d = 1'b1;
            end
         end
         ST_BIT_LOW: begin
            drive_low_d = 1'b1; // see [RL12]
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == CNT_W'(BIT_LOW_N - 1)) begin
               // Back to sleep after the closing low ends the transaction, see [RL15]
               cnt_d       = '0;
               drive_low_d = 1'b0;
               state_d     = (bits_q == 6'(FRAME_BITS)) ? ST_SLEEP : ST_BIT_HIGH;
               done_d      = (bits_q == 6'(FRAME_BITS));
            end
         end
         ST_BIT_HIGH: begin
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == (shift_q[39] ? CNT_W'(ONE_HIGH_N - 1) : CNT_W'(ZERO_HIGH_N - 1))) begin // see [RL12]
               cnt_d       = '0;
               shift_d     = {shift_q[38:0], 1'b0}; // see [RL1]
               bits_d      = bits_q + 6'd1;
               drive_low_d = 1'b1;
               // Closing low after the last bit reuses the bit-low timing, see [RL14]
               state_d     = ST_BIT_LOW;
            end
         end
         default: begin
            state_d = ST_SLEEP;
            cnt_d   = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q     <= ST_SLEEP;
         cnt_q       <= '0;
         shift_q     <= '0;
         bits_q      <= '0;
         drive_low_q <= 1'b0;
         done_q      <= 1'b0;
      end else begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         shift_q     <= shift_d;
         bits_q      <= bits_d;
         drive_low_q <= drive_low_d;
         done_q      <= done_d;
      end
   end

   // =========================================================
   // Pin drive: open drain, released when idle, see [RL6]
   assign line_o       = 1'b0;
   assign line_oe_o    = drive_low_q;
   assign awake_o      = (state_q != ST_SLEEP); // see [RL5]
   assign frame_done_o = done_q;
endmodule

// [verification/climate_link_asserts.sv]
// Purpose: Line timing checks
// Assumes: Bound to the device end
// Notes:   Lengths in cycles
`timescale 1ns/1ps
module climate_link_asserts
   import climate_link_pkg::*;
#(
   parameter int unsigned US_CYC = 50
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic line_i,
   input wire logic line_o,
   input wire logic line_oe_o,
   input wire logic awake_o,
   input wire logic frame_done_o
);
   logic [12:0] run_q;
   logic [5:0]  fall_q;
   logic        oe_q;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_q <= 13'h0001;
         fall_q <= 6'h00;
         oe_q <= 1'b0;
      end else begin
         oe_q <= line_oe_o;
         run_q <= (line_oe_o != oe_q) ? 13'h0001 : run_q + 13'h0001;
         fall_q <= !awake_o ? 6'h00 : fall_q + 6'((oe_q && !line_oe_o) ? 1 : 0);
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   a_idle_quiet: assert property (!awake_o |-> !line_oe_o) else $error("idle drive");
   a_open_drain: assert property (line_oe_o |-> !line_o) else $error("drives high");
   a_wake_start: assert property ($rose(awake_o) |-> !line_oe_o && !line_i)
      else $error("bad wake");
   a_resp_low: assert property ($fell(line_oe_o) && fall_q == 6'h00 |-> run_q == 13'(RESP_LOW_US * US_CYC))
      else $error("response low");
   a_resp_high: assert property ($rose(line_oe_o) && fall_q == 6'h01 |-> run_q == 13'(RESP_HIGH_US * US_CYC))
      else $error("response high");
   a_bit_low: assert property ($fell(line_oe_o) && fall_q != 6'h00 |-> run_q == 13'(BIT_LOW_US * US_CYC))
      else $error("bit low");
   a_bit_high: assert property ($rose(line_oe_o) && fall_q > 6'h01 |->
      run_q == 13'(ZERO_HIGH_US * US_CYC) || run_q == 13'(ONE_HIGH_US * US_CYC))
      else $error("bit high");
   a_frame_end: assert property (frame_done_o |-> $fell(line_oe_o) && !awake_o && fall_q == 6'h29)
      else $error("frame end");
endmodule
bind climate_link_device climate_link_asserts #(.US_CYC(US_CYC)) climate_link_asserts_i (.clk_sys_i(clk_sys_i),
   .rst_b_i(rst_b_i),
   .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o), .awake_o(awake_o), .frame_done_o(frame_done_o));

// [verification/climate_host_model.sv]
// Purpose: Host end of the data line
// Assumes: Line resolved by the bench
// Notes:   Start pulse scaled to START_CYC
`timescale 1ns/1ps
module climate_host_model #(
   parameter int unsigned START_CYC = 50,
   parameter int unsigned US_CYC    = 50
) (
   input  wire logic clk_sys_i,
   input  wire logic line_i,
   output logic      host_oe_o
);
   localparam int LIMIT = 100 * US_CYC;
   initial host_oe_o = 1'b0;
   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      while (line_i !== v && n < LIMIT) begin
         @(posedge clk_sys_i);
         n++;
      end
   endtask
   task automatic pulse(input int len);
      @(posedge clk_sys_i);
      host_oe_o <= 1'b1;
      repeat (len) @(posedge clk_sys_i);
      host_oe_o <= 1'b0;
   endtask
   task automatic read_frame(output logic [39:0] f, output logic ok);
      int n;
      ok = 1'b1;
      pulse(START_CYC + 10);
      repeat (30 * US_CYC) @(posedge clk_sys_i);
      if (line_i !== 1'b0) ok = 1'b0;
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
      for (int i = 39; i >= 0; i--) begin
         wait_lvl(1'b1, n);
         wait_lvl(1'b0, n);
         f[i] = (n > 48 * US_CYC);
         if (n >= LIMIT) ok = 1'b0;
      end
      wait_lvl(1'b1, n);
      if (n >= LIMIT) ok = 1'b0;
   endtask
endmodule

// [verification/climate_link_device_tb.sv]
// Purpose: Self-checking bench for the device end
// Assumes: Host model on the line
// Notes:   Start threshold cut to 50 cycles
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH %0t differs", $time); end end
module climate_link_device_tb;
   logic       clk_sys_i = 1'b0;
   logic       rst_b_i = 1'b0;
   logic [7:0] humidity_i = 8'h00;
   logic [7:0] temperature_i = 8'h00;
   logic       sample_valid_i = 1'b0;
   logic       host_oe, line_o, line_oe_o, sample_ready_o, awake_o, frame_done_o;
   wire        line_w = ~(line_oe_o | host_oe);
   int         miscompares = 0;
   int         total_checks = 0;
   int         done_cnt = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (frame_done_o === 1'b1) done_cnt++;
   climate_link_device #(.START_CYC(50), .US_CYC(5)) climate_link_device_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .line_i(line_w), .line_o(line_o), .line_oe_o(line_oe_o), .humidity_i(humidity_i),
      .temperature_i(temperature_i), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
      .awake_o(awake_o), .frame_done_o(frame_done_o));
   climate_host_model #(.START_CYC(50), .US_CYC(5)) climate_host_model_i (.clk_sys_i(clk_sys_i), .line_i(line_w),
      .host_oe_o(host_oe));
   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic t_fill();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys_i);
         `CHK(sample_ready_o, 1'b1)
         humidity_i <= 8'hC8 - 8'(i);
         temperature_i <= 8'h5A + 8'(i);
         sample_valid_i <= 1'b1;
      end
      @(posedge clk_sys_i);
      sample_valid_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      `CHK(sample_ready_o, 1'b0)
      $display("Test fill done");
   endtask
   task automatic t_short();
      climate_host_model_i.pulse(20);
      repeat (300) @(posedge clk_sys_i);
      `CHK(awake_o, 1'b0)
      `CHK(line_w, 1'b1)
      $display("Test short pulse done");
   endtask
   task automatic t_frame(input logic [7:0] h, input logic [7:0] t);
      logic [39:0] f;
      logic        ok;
      int          d0;
      d0 = done_cnt;
      climate_host_model_i.read_frame(f, ok);
      repeat (2) @(posedge clk_sys_i);
      `CHK(ok, 1'b1)
      `CHK(f[39:32], h)
      `CHK(f[31:24], 8'h00)
      `CHK(f[23:16], t)
      `CHK(f[15:8], 8'h00)
      `CHK(f[7:0], 8'(h + t))
      `CHK(awake_o, 1'b0)
      `CHK(line_w, 1'b1)
      `CHK(line_o, 1'b0)
      `CHK(done_cnt, d0 + 1)
      `CHK(sample_ready_o, 1'b1)
      $display("Test frame done");
   endtask
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      t_fill();
      t_short();
      t_frame(8'hC8, 8'h5A);
      t_frame(8'hC7, 8'h5B);
      report_and_stop();
   end
   initial begin
      repeat (80000) @(posedge clk_sys_i);
      miscompares++;
      report_and_stop();
   end
endmodule
